/* File: rtl/asr_pkg.sv */
package asr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and word
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned WORD_W  = 24;
    localparam logic [4:0]  WORD_BITS = 5'h18;
    localparam logic [23:0] CODE_MID = 24'h800000;
    localparam logic [23:0] CODE_MAX = 24'hFFFFFF;
    localparam logic [23:0] CODE_MIN = 24'h000000;

    ////////////////////////////////////////////////////////////////////////
    // Times and derived cycle counts
    localparam int unsigned PD_MIN_NS   = 100;
    localparam int unsigned PD_MIN_CYC  = (PD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PWRUP_US    = 1000;
    localparam int unsigned PWRUP_CYC   = PWRUP_US * CLK_MHZ;
    localparam int unsigned PER_10_US   = 100000;
    localparam int unsigned PER_50_US   = 20000;
    localparam int unsigned PER_60_US   = 16666;
    localparam int unsigned PER_120_US  = 8333;
    localparam int unsigned PER_10_CYC  = PER_10_US * CLK_MHZ;
    localparam int unsigned PER_50_CYC  = PER_50_US * CLK_MHZ;
    localparam int unsigned PER_60_CYC  = PER_60_US * CLK_MHZ;
    localparam int unsigned PER_120_CYC = PER_120_US * CLK_MHZ;
    localparam int unsigned SETTLE_CONV = 4;
    localparam int unsigned GUARD_CYC   = 16;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CFG  = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_RES  = 8'h08;
    localparam int unsigned CFG_W    = 7;
    localparam logic [6:0] CFG_RST   = 7'h40;

    // Gain code to left shift: 1, 8, 64, 128
    localparam logic [2:0] SH_G1   = 3'h0;
    localparam logic [2:0] SH_G8   = 3'h3;
    localparam logic [2:0] SH_G64  = 3'h6;
    localparam logic [2:0] SH_G128 = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic       clk_int;
        logic       temp;
        logic       chan;
        logic [1:0] gain;
        logic [1:0] rate;
    } asr_cfg_t;

    typedef enum logic [3:0] {
        ST_OFF    = 4'h1,
        ST_PWRUP  = 4'h2,
        ST_SETTLE = 4'h4,
        ST_RUN    = 4'h8
    } asr_state_t;

    typedef struct packed {
        logic [23:0] pos;
        logic [23:0] neg;
    } asr_pair_t;

endpackage

/* File: rtl/asr_sync.sv */
`timescale 1ns/1ps
module asr_sync (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Async levels in, synced levels out
    input  wire logic [1:0] d_i,
    output logic      [1:0] q_o
);

    logic [1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Upper bit resets asleep, so a held sleep pin gives no false wake
            meta_q <= 2'h2;
            q_o    <= 2'h2;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

/* File: rtl/asr_readout.sv */
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module asr_readout #(
    parameter int unsigned P_PWRUP_CYC = asr_pkg::PWRUP_CYC,
    parameter int unsigned P_PER_10    = asr_pkg::PER_10_CYC,
    parameter int unsigned P_PER_50    = asr_pkg::PER_50_CYC,
    parameter int unsigned P_PER_60    = asr_pkg::PER_60_CYC,
    parameter int unsigned P_PER_120   = asr_pkg::PER_120_CYC
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Pins
    input  wire logic              sleep_reset_pin_i,
    input  wire logic              sclk_i,
    output logic                   dout_rdy_o,
    output logic                   dout_rdy_oe_o,
    output logic                   bridge_disconnect_switch_o,
    // Front-end samples, same clock
    input  wire asr_pkg::asr_pair_t input_pair_a_i,
    input  wire asr_pkg::asr_pair_t input_pair_b_i,
    input  wire logic [23:0]       temp_code_i
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] pin_s;
    logic       pd_s;
    logic       sclk_s;
    logic       sclk_prev_q;
    logic       sclk_rise;
    logic       sclk_fall;

    asr_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({sleep_reset_pin_i, sclk_i}),
        .q_o   (pin_s)
    );

    assign pd_s      = pin_s[1];
    assign sclk_s    = pin_s[0];
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    asr_pkg::asr_state_t st_q;
    asr_pkg::asr_state_t st_d;
    asr_pkg::asr_cfg_t   cfg_q;
    asr_pkg::asr_cfg_t   seen_q;
    logic [4:0]          pd_cnt_q;
    logic [31:0]         tmr_q;
    logic [31:0]         tmr_d;
    logic [2:0]          settle_n_q;
    logic [23:0]         sh_q;
    logic [23:0]         sh_d;
    logic [4:0]          bit_q;
    logic [4:0]          bit_d;
    logic                avail_q;
    logic                avail_d;
    logic                dout_q;
    logic                dout_d;
    logic [23:0]         last_q;
    logic [31:0]         rd_d;
    logic                pd_hit;
    logic                cfg_chg;
    logic                active;
    logic [31:0]         per_w;
    logic                per_end;
    logic                pwr_end;
    logic                settle_last;
    logic                load_w;
    logic                guard_w;
    logic                shift_w;
    logic                done_w;
    logic                wb_req;
    logic                wb_wr_cfg;

    ////////////////////////////////////////////////////////////////////////
    // Result coding
    logic signed [24:0] diff_w;
    logic        [2:0]  gsh_w;
    logic signed [32:0] gained_w;
    logic signed [32:0] code_w;
    logic        [23:0] conv_w;
    logic        [23:0] res_w;

    // Positive input measured against its own negative input
    assign diff_w = cfg_q.chan
        ? ($signed({input_pair_b_i.pos[23], input_pair_b_i.pos})
           - $signed({input_pair_b_i.neg[23], input_pair_b_i.neg}))
        : ($signed({input_pair_a_i.pos[23], input_pair_a_i.pos})
           - $signed({input_pair_a_i.neg[23], input_pair_a_i.neg}));
    assign gsh_w = (cfg_q.gain == 2'h0) ? asr_pkg::SH_G1 :
                   (cfg_q.gain == 2'h1) ? asr_pkg::SH_G8 :
                   (cfg_q.gain == 2'h2) ? asr_pkg::SH_G64 : asr_pkg::SH_G128;
    assign gained_w = $signed({{8{diff_w[24]}}, diff_w}) <<< gsh_w;
    assign code_w   = gained_w + $signed({9'h000, asr_pkg::CODE_MID});
    // Clip beyond full scale rather than wrap
    assign conv_w = (code_w < 0) ? asr_pkg::CODE_MIN :
                    (code_w > $signed({9'h000, asr_pkg::CODE_MAX})) ? asr_pkg::CODE_MAX :
                    code_w[23:0];
    assign res_w = cfg_q.temp ? temp_code_i : conv_w;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing
    assign pd_hit  = pd_s && (pd_cnt_q == 5'(asr_pkg::PD_MIN_CYC - 1));
    assign active  = (st_q == asr_pkg::ST_SETTLE) || (st_q == asr_pkg::ST_RUN);
    assign cfg_chg = active && (cfg_q != seen_q);
    assign per_w   = (cfg_q.rate == 2'h0) ? P_PER_10 :
                     (cfg_q.rate == 2'h1) ? P_PER_50 :
                     (cfg_q.rate == 2'h2) ? P_PER_60 : P_PER_120;
    assign per_end = active && (tmr_q == per_w - 32'h1);
    assign pwr_end = (st_q == asr_pkg::ST_PWRUP) && (tmr_q == P_PWRUP_CYC - 32'h1);
    assign settle_last = settle_n_q == 3'(asr_pkg::SETTLE_CONV - 1);

    always_comb begin
        st_d = st_q;
        case (st_q)
            asr_pkg::ST_OFF: begin
                // External clock needs no start-up wait
                if (!pd_s) begin
                    st_d = cfg_q.clk_int ? asr_pkg::ST_PWRUP : asr_pkg::ST_SETTLE;
                end
            end
            asr_pkg::ST_PWRUP: begin
                if (pwr_end) begin
                    st_d = asr_pkg::ST_SETTLE;
                end
            end
            asr_pkg::ST_SETTLE: begin
                if (per_end && settle_last) begin
                    st_d = asr_pkg::ST_RUN;
                end
            end
            asr_pkg::ST_RUN: begin
                st_d = asr_pkg::ST_RUN;
            end
            default: begin
                st_d = asr_pkg::ST_OFF;
            end
        endcase
        if (pd_hit) begin
            st_d = asr_pkg::ST_OFF;
        end else if (cfg_chg) begin
            st_d = asr_pkg::ST_SETTLE;
        end
    end

    assign tmr_d = ((st_d != st_q) || cfg_chg || per_end) ? 32'h0 : tmr_q + 32'h1;

    ////////////////////////////////////////////////////////////////////////
    // Serial output
    assign load_w  = per_end && (st_d == asr_pkg::ST_RUN);
    assign guard_w = (st_q == asr_pkg::ST_RUN) && avail_q && (bit_q == 5'h0)
                     && (tmr_q == per_w - 32'(asr_pkg::GUARD_CYC) - 32'h1);
    assign shift_w = avail_q && sclk_rise && (bit_q < asr_pkg::WORD_BITS);
    assign done_w  = avail_q && sclk_fall && (bit_q == asr_pkg::WORD_BITS);

    always_comb begin
        dout_d  = dout_q;
        avail_d = avail_q;
        sh_d    = sh_q;
        bit_d   = bit_q;
        if (st_d != asr_pkg::ST_RUN) begin
            dout_d  = 1'b1;
            avail_d = 1'b0;
            bit_d   = 5'h0;
        end else if (load_w) begin
            sh_d    = res_w;
            bit_d   = 5'h0;
            avail_d = 1'b1;
            dout_d  = 1'b0;
        end else if (guard_w) begin
            dout_d  = 1'b1;
            avail_d = 1'b0;
        end else if (shift_w) begin
            dout_d  = sh_q[23];
            sh_d    = {sh_q[22:0], 1'b0};
            bit_d   = bit_q + 5'h1;
        end else if (done_w) begin
            dout_d  = 1'b1;
            avail_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr_cfg = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == asr_pkg::ADDR_CFG);

    always_comb begin
        if (wb_adr_i == asr_pkg::ADDR_CFG) begin
            rd_d = {25'h0, cfg_q};
        end else if (wb_adr_i == asr_pkg::ADDR_STAT) begin
            rd_d = {24'h0, dout_q, avail_q, pd_s, 1'b0, st_q};
        end else if (wb_adr_i == asr_pkg::ADDR_RES) begin
            rd_d = {8'h00, last_q};
        end else begin
            rd_d = 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            cfg_q    <= asr_pkg::CFG_RST;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_d : 32'h0;
            if (wb_wr_cfg) begin
                cfg_q <= asr_pkg::asr_cfg_t'(wb_dat_i[asr_pkg::CFG_W-1:0]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev_q <= 1'b0;
            pd_cnt_q    <= 5'h0;
            seen_q      <= asr_pkg::CFG_RST;
            st_q        <= asr_pkg::ST_OFF;
            tmr_q       <= 32'h0;
        end else begin
            sclk_prev_q <= sclk_s;
            seen_q      <= cfg_q;
            st_q        <= st_d;
            tmr_q       <= tmr_d;
            if (!pd_s) begin
                pd_cnt_q <= 5'h0;
            end else if (!pd_hit) begin
                pd_cnt_q <= pd_cnt_q + 5'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || st_q != asr_pkg::ST_SETTLE || cfg_chg) begin
            settle_n_q <= 3'h0;
        end else if (per_end) begin
            settle_n_q <= settle_n_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_q  <= 1'b1;
            avail_q <= 1'b0;
            sh_q    <= 24'h0;
            bit_q   <= 5'h0;
            last_q  <= 24'h0;
        end else begin
            dout_q  <= dout_d;
            avail_q <= avail_d;
            sh_q    <= sh_d;
            bit_q   <= bit_d;
            if (load_w) begin
                last_q <= res_w;
            end
        end
    end

    // Pin drivers; tristate and bridge follow the pin, not the filtered reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_rdy_o                 <= 1'b1;
            dout_rdy_oe_o              <= 1'b0;
            bridge_disconnect_switch_o <= 1'b0;
        end else begin
            dout_rdy_o                 <= dout_d;
            dout_rdy_oe_o              <= ~pd_s;
            bridge_disconnect_switch_o <= ~pd_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_BRIDGE_CLOSED: assert property (!pd_s |=> bridge_disconnect_switch_o)
        else $error("bridge switch not closed while awake");
    AST_BRIDGE_OPEN: assert property (pd_s |=> !bridge_disconnect_switch_o)
        else $error("bridge switch not open while asleep");
    AST_TRISTATE: assert property (pd_s |=> !dout_rdy_oe_o)
        else $error("output driven while asleep");
    AST_READY_LOW: assert property (load_w |=> !dout_rdy_o && avail_q && bit_q == 5'h0)
        else $error("ready not signalled on new word");
    AST_MSB_FIRST: assert property (shift_w && !load_w && !guard_w
        && st_d == asr_pkg::ST_RUN |=> dout_rdy_o == $past(sh_q[23]))
        else $error("serial bit out of order");
    AST_READ_DONE: assert property (done_w && !load_w && st_d == asr_pkg::ST_RUN
        |=> dout_rdy_o && !avail_q)
        else $error("output not high after full read");
    AST_ONCE: assert property (!avail_q && !load_w |=> dout_rdy_o)
        else $error("output low without a fresh word");
    AST_GUARD: assert property (guard_w && st_d == asr_pkg::ST_RUN
        |=> dout_rdy_o [*2])
        else $error("unread word not withdrawn before update");
    AST_CFG_RESTART: assert property (cfg_chg && !pd_hit
        |=> st_q == asr_pkg::ST_SETTLE && dout_rdy_o && tmr_q == 32'h0)
        else $error("config change did not restart");
    AST_SETTLE_HIGH: assert property (st_q == asr_pkg::ST_SETTLE |-> dout_rdy_o)
        else $error("output low during settling");
    // Run length of the synced sleep level, counted apart from the design's own counter
    logic [4:0] pd_run_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || !pd_s) begin
            pd_run_q <= 5'h0;
        end else if (pd_run_q != 5'(asr_pkg::PD_MIN_CYC)) begin
            pd_run_q <= pd_run_q + 5'h1;
        end
    end

    AST_PD_RESET: assert property (pd_s && pd_run_q >= 5'(asr_pkg::PD_MIN_CYC - 1)
        |=> st_q == asr_pkg::ST_OFF)
        else $error("sleep pin did not reset");
    AST_WAKE_HIGH: assert property ($fell(pd_s) |-> dout_rdy_o [*2])
        else $error("output not high after wake");
    AST_MIDSCALE: assert property (load_w && !cfg_q.temp && diff_w == 25'sh0
        |=> dout_rdy_oe_o && sh_q == asr_pkg::CODE_MID)
        else $error("zero input not midscale");

endmodule

/* File: tb/asr_host_model.sv */
`timescale 1ns/1ps
module asr_host_model #(
    parameter int HALF_NS = 32
) (
    // Bench control
    input  wire logic        start_i,
    input  wire logic        slow_i,
    // Link
    input  wire logic        dat_i,
    output logic             sclk_o,
    // Result
    output logic             busy_o,
    output logic [23:0]      word_o
);
    // Clock stands still between frames; slow mode doubles each half period
    initial begin
        sclk_o = 1'b0;
        busy_o = 1'b0;
        word_o = 24'h000000;
        forever begin
            @(posedge start_i);
            busy_o = 1'b1;
            for (int i = 0; i < 24; i++) begin
                #(slow_i ? 2 * HALF_NS : HALF_NS) sclk_o = 1'b1;
                #(slow_i ? 2 * HALF_NS : HALF_NS) word_o = {word_o[22:0], dat_i};
                sclk_o = 1'b0;
            end
            #(HALF_NS) busy_o = 1'b0;
        end
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int PWR = 100;
    int                 per_t[4]  = '{1800, 1500, 1300, 1200};
    int                 gain_t[4] = '{1, 8, 64, 128};
    logic [6:0]         cfg_t[6]  = '{7'h41, 7'h46, 7'h5B, 7'h4C, 7'h72, 7'h11};
    logic [47:0]        fix_t[4]  = '{48'h0, 48'h400000C00000, 48'h5A5A5A5A5A5A,
                                      48'hC00000400000};
    logic               clk_i, rst_i, wb_cyc, wb_stb, wb_we, sleep, start, slow;
    logic [7:0]         wb_adr;
    logic [3:0]         wb_sel;
    logic [31:0]        wb_wdat, wb_rdat, wq;
    logic               wb_ack, dout, oe, bridge, sclk, link, hbusy;
    logic               last_q = 1'b0;
    logic [23:0]        tcode, hword;
    logic [6:0]         cfg;
    asr_pkg::asr_pair_t pa, pb;
    logic [23:0]        expq[$];
    int                 mismatches = 0, checks_done = 0, cyc_n = 0, seed, n, t0;

    asr_readout #(.P_PWRUP_CYC(PWR), .P_PER_10(1800), .P_PER_50(1500),
        .P_PER_60(1300), .P_PER_120(1200)) asr_readout_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .sleep_reset_pin_i(sleep),
        .sclk_i(sclk), .dout_rdy_o(dout), .dout_rdy_oe_o(oe),
        .bridge_disconnect_switch_o(bridge), .input_pair_a_i(pa),
        .input_pair_b_i(pb), .temp_code_i(tcode));

    asr_host_model asr_host_model_i (.start_i(start), .slow_i(slow), .dat_i(link),
        .sclk_o(sclk), .busy_o(hbusy), .word_o(hword));

    // Released line shows the inverse of its last level, never a stale value
    assign link = oe ? dout : ~last_q;

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (oe === 1'b1) last_q <= dout;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic fail;
        mismatches++;
        results();
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic win(input int v, input int lo, input int span);
        return v >= lo && v <= lo + span;
    endfunction

    // Clipped because a wide input at high gain leaves the 24-bit range
    function automatic logic [23:0] code_of(input logic [6:0] c);
        asr_pkg::asr_pair_t s;
        longint             d;
        s = c[4] ? pb : pa;
        d = (longint'($signed(s.pos)) - longint'($signed(s.neg))) * gain_t[c[3:2]];
        d = d + 64'sh800000;
        if (c[5]) return tcode;
        if (d < 0) return 24'h000000;
        if (d > 64'shFFFFFF) return 24'hFFFFFF;
        return d[23:0];
    endfunction

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_adr  <= a;
        wb_sel  <= 4'hF;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        wq = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k >= 50) fail();
        @(posedge clk_i);
    endtask

    task automatic set_in(input int m);
        @(posedge clk_i);
        if (m == 0) begin
            pa.pos <= 24'($random(seed) >>> 12);
            pa.neg <= 24'($random(seed) >>> 12);
            pb.pos <= 24'($random(seed) >>> 12);
            pb.neg <= 24'($random(seed) >>> 12);
        end else begin
            pa <= fix_t[m];
            pb <= fix_t[m];
        end
        tcode <= 24'($random(seed));
        @(posedge clk_i);
    endtask

    task automatic rd(input logic s, input logic [23:0] e);
        int k;
        expq.push_back(e);
        @(posedge clk_i);
        slow  <= s;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        k = 0;
        while (hbusy !== 1'b0 && k < 900) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 900) fail();
    endtask

    task automatic wait_lvl(input logic lvl, input int lim);
        n = 0;
        while (link !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim) fail();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1;
        forever begin
            @(negedge hbusy);
            if (expq.size() == 0) begin
                mismatches++;
                $display("unexpected word: expected none seen %h", hword);
            end else begin
                chk_word("word", {8'h00, expq.pop_front()}, {8'h00, hword});
            end
        end
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        fail();
    end

    initial begin
        seed = 32'h52C6F8F9;
        {rst_i, sleep} = 2'h3;
        {wb_cyc, wb_stb, wb_we, start, slow} = 5'h00;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_wdat = 32'h0;
        {pa, pb, tcode} = '0;
        cfg = asr_pkg::CFG_RST;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_bit("oe asleep", 1'b0, oe);
        chk_bit("bridge asleep", 1'b0, bridge);
        wb(asr_pkg::ADDR_CFG, 1'b0, 32'h0);
        chk_word("cfg reset", {25'h0, asr_pkg::CFG_RST}, wq);
        wb(8'h0C, 1'b1, 32'hFFFFFFFF);
        wb(8'h0C, 1'b0, 32'h0);
        chk_word("unmapped", 32'h0, wq);
        set_in(1);
        sleep <= 1'b0;
        t0 = cyc_n;
        repeat (5) @(posedge clk_i);
        chk_bit("bridge awake", 1'b1, bridge);
        chk_bit("line after wake", 1'b1, link);
        wait_lvl(1'b0, 9000);
        chk_bit("first word time", 1'b1, win(cyc_n - t0, PWR + 4 * per_t[0], 12));
        rd(1'b0, code_of(cfg));
        for (int k = 0; k < 6; k++) begin
            wait_lvl(1'b0, 2000);
            cfg = cfg_t[k];
            set_in(k == 0 ? 3 : 0);
            wb(asr_pkg::ADDR_CFG, 1'b1, {25'h0, cfg});
            t0 = cyc_n;
            chk_bit("line after change", 1'b1, link);
            rd(1'b0, 24'hFFFFFF);
            wait_lvl(1'b0, 9000);
            chk_bit("settle time", 1'b1, win(cyc_n - t0, 4 * per_t[cfg[1:0]] - 4, 12));
            rd(k[0], code_of(cfg));
            set_in(k == 0 ? 2 : 0);
            wait_lvl(1'b0, 2000);
            rd(k[1], code_of(cfg));
            rd(1'b0, 24'hFFFFFF);
        end
        wait_lvl(1'b0, 2000);
        set_in(0);
        wait_lvl(1'b1, 2000);
        wait_lvl(1'b0, 100);
        chk_bit("guard", 1'b1, win(n, asr_pkg::GUARD_CYC - 1, 4));
        rd(1'b0, code_of(cfg));
        wait_lvl(1'b0, 2000);
        sleep <= 1'b1;
        repeat (30) @(posedge clk_i);
        chk_bit("oe asleep", 1'b0, oe);
        chk_bit("bridge open", 1'b0, bridge);
        sleep <= 1'b0;
        t0 = cyc_n;
        repeat (5) @(posedge clk_i);
        chk_bit("word dropped", 1'b1, link);
        // External clock skips the start-up wait
        wait_lvl(1'b0, 9000);
        chk_bit("wake time", 1'b1, win(cyc_n - t0, 4 * per_t[cfg[1:0]], 12));
        rd(1'b0, code_of(cfg));
        results();
    end
endmodule
